//--- rtl/ech_pkg.sv
package ech_pkg;

    // register indices; byte address is four times the index
    localparam logic [13:0] ECH_IDX_HP1_GND   = 14'h0412;
    localparam logic [13:0] ECH_IDX_HP2_GND   = 14'h041a;
    localparam logic [13:0] ECH_IDX_HP34_GND  = 14'h0422;
    localparam logic [13:0] ECH_IDX_LB_ONE    = 14'h0450;
    localparam logic [13:0] ECH_IDX_LB_TWO    = 14'h0451;
    localparam logic [13:0] ECH_IDX_IRQ_STAT  = 14'h0460;
    localparam logic [13:0] ECH_IDX_IRQ_MASK  = 14'h0461;
    localparam logic [13:0] ECH_IDX_MIN_CLK   = 14'h0462;

    // loop-back control fields and ground selector MSB
    localparam int unsigned ECH_ENA_BIT  = 0;
    localparam int unsigned ECH_STS_BIT  = 1;
    localparam int unsigned ECH_SRC_LSB  = 2;
    localparam int unsigned ECH_SRC_MSB  = 5;
    localparam int unsigned ECH_GND_MSB  = 2;

    // reset values
    localparam logic [2:0]  ECH_HP1_GND_RST  = 3'h0;
    localparam logic [2:0]  ECH_HP2_GND_RST  = 3'h2;
    localparam logic [2:0]  ECH_HP34_GND_RST = 3'h2;
    localparam logic [3:0]  ECH_MIN_CLK_RST  = 4'h3;
    localparam logic [3:0]  ECH_IRQ_MASK_RST = 4'h0;

    // interrupt status bit positions
    localparam int unsigned ECH_IRQ_ON_LSB   = 0;
    localparam int unsigned ECH_IRQ_REF_LSB  = 2;

    typedef enum logic [3:0] {
        ECH_SRC_ONE_LEFT    = 4'h0,
        ECH_SRC_ONE_RIGHT   = 4'h1,
        ECH_SRC_TWO_LEFT    = 4'h2,
        ECH_SRC_TWO_RIGHT   = 4'h3,
        ECH_SRC_THREE_LEFT  = 4'h4,
        ECH_SRC_THREE_RIGHT = 4'h5,
        ECH_SRC_FIVE_LEFT   = 4'h8,
        ECH_SRC_FIVE_RIGHT  = 4'h9
    } ech_src_type;

    localparam logic [2:0]  ECH_GND_INTERNAL_ANALOG_GROUND     = 3'h5;

    // loop-back path state, gray along off, check, on
    typedef enum logic [1:0] {
        ECH_LB_OFF     = 2'b00,
        ECH_LB_CHECK   = 2'b01,
        ECH_LB_ON      = 2'b11,
        ECH_LB_REFUSED = 2'b10
    } ech_lb_state_type;

    typedef struct packed {
        logic       internal_analog_ground;
        logic [4:0] ground_feedback_pin;
    } ech_gnd_route_type;

    typedef struct packed {
        ech_gnd_route_type headphone_three_four;
        ech_gnd_route_type headphone_two;
        ech_gnd_route_type headphone_one;
    } ech_hp_ground_type;

endpackage : ech_pkg

//--- rtl/ech_loopback_ctrl.sv
`timescale 1ns/100ps
module ech_loopback_ctrl
    import ech_pkg::*;
#(
    parameter int SAMPLE_W = 24,
    parameter int RATE_W   = 5,
    parameter int CLK_W    = 4
) (
    input  wire logic                             clk,
    input  wire logic                             sys_rst,
    input  wire logic                             hsel,
    input  wire logic [31:0]                      haddr,
    input  wire logic [1:0]                       htrans,
    input  wire logic                             hwrite,
    input  wire logic [2:0]                       hsize,
    input  wire logic [31:0]                      hwdata,
    input  wire logic                             hready,
    output logic      [31:0]                      hrdata,
    output logic                                  hreadyout,
    output logic                                  hresp,
    input  wire logic [7:0][SAMPLE_W-1:0]         output_paths,
    input  wire logic                             sample_strobe,
    input  wire logic [RATE_W-1:0]                output_rate,
    input  wire logic [CLK_W-1:0]                 system_clock_rate,
    output logic      [1:0][SAMPLE_W-1:0]         echo_ref_data,
    output logic      [1:0]                       echo_ref_valid,
    output logic      [RATE_W-1:0]                echo_ref_rate,
    output ech_hp_ground_type                     headphone_ground,
    output logic                                  irq
);

    if (SAMPLE_W < 1 || SAMPLE_W > 32 || RATE_W < 1 || CLK_W != 4) begin : g_bad_param
        $error("ech_loopback_ctrl: unsupported parameter values");
    end

    // package field layout must match the decode below
    if (ECH_SRC_MSB - ECH_SRC_LSB != 3) begin : g_bad_src_field
        $error("ech_loopback_ctrl: source field must be four bits");
    end
    if (ECH_GND_MSB != 2) begin : g_bad_gnd_field
        $error("ech_loopback_ctrl: ground selector must be three bits");
    end
    if (ECH_ENA_BIT == ECH_STS_BIT) begin : g_bad_ctrl_bits
        $error("ech_loopback_ctrl: enable and status bits overlap");
    end
    if (ECH_SRC_LSB <= ECH_STS_BIT) begin : g_bad_src_pos
        $error("ech_loopback_ctrl: source field overlaps status bit");
    end
    if (ECH_IRQ_REF_LSB != ECH_IRQ_ON_LSB + 2) begin : g_bad_irq_pos
        $error("ech_loopback_ctrl: interrupt bit layout unsupported");
    end
    if (ECH_IDX_LB_TWO != ECH_IDX_LB_ONE + 14'h0001) begin : g_bad_lb_idx
        $error("ech_loopback_ctrl: loop-back registers must be adjacent");
    end
    if (ECH_IDX_LB_ONE[0] != 1'b0) begin : g_bad_lb_align
        $error("ech_loopback_ctrl: first loop-back index must be even");
    end
    if (ECH_GND_INTERNAL_ANALOG_GROUND != 3'h5) begin : g_bad_internal_analog_ground_code
        $error("ech_loopback_ctrl: ground code layout unsupported");
    end

    typedef struct packed {
        logic [31:0]                hrdata;
        logic                       hreadyout;
        logic                       dp_write;
        logic [13:0]                dp_idx;
        logic [2:0][2:0]            gnd_sel;
        ech_hp_ground_type          gnd_route;
        logic [1:0]                 ena;
        logic [1:0][3:0]            src;
        ech_lb_state_type [1:0]     lb;
        logic [1:0][SAMPLE_W-1:0]   ref_data;
        logic [1:0]                 ref_valid;
        logic [RATE_W-1:0]          rate;
        logic [3:0]                 irq_status;
        logic [3:0]                 irq_mask;
        logic [CLK_W-1:0]           min_clk;
        logic                       irq;
    } ech_state_type;

    ech_state_type r;
    ech_state_type next_r;

    // source code to post-volume sample; reserved codes give silence
    function automatic logic [SAMPLE_W-1:0] pick_source(
        input logic [3:0]               code,
        input logic [7:0][SAMPLE_W-1:0] paths
    );
        logic [SAMPLE_W-1:0] s;
        s = '0;
        case (code)
            ECH_SRC_ONE_LEFT,
            ECH_SRC_ONE_RIGHT,
            ECH_SRC_TWO_LEFT,
            ECH_SRC_TWO_RIGHT,
            ECH_SRC_THREE_LEFT,
            ECH_SRC_THREE_RIGHT: s = paths[code[2:0]];
            ECH_SRC_FIVE_LEFT:   s = paths[6];
            ECH_SRC_FIVE_RIGHT:  s = paths[7];
            default:             s = '0;
        endcase
        return s;
    endfunction : pick_source

    // selector code to one-hot ground route; codes 6 and 7 give no route
    function automatic ech_gnd_route_type route_ground(input logic [2:0] code);
        ech_gnd_route_type g;
        g = '0;
        if (code == ECH_GND_INTERNAL_ANALOG_GROUND) begin
            g.internal_analog_ground = 1'b1;
        end else if (code < ECH_GND_INTERNAL_ANALOG_GROUND) begin
            g.ground_feedback_pin = 5'(5'h01 << code);
        end
        return g;
    endfunction : route_ground

    always_comb begin
        logic [1:0]     wr_lb;
        logic [3:0]     irq_set;
        logic [3:0]     irq_clr;
        logic [13:0]    idx;
        next_r = r;
        wr_lb = '0;
        irq_set = '0;
        irq_clr = '0;
        idx = haddr[15:2];
        next_r.dp_write = 1'b0;
        next_r.ref_valid = '0;
        next_r.hreadyout = 1'b1;
        next_r.rate = output_rate;

        // data phase of a write
        if (r.dp_write) begin
            if (r.dp_idx == ECH_IDX_HP1_GND) begin
                next_r.gnd_sel[0] = hwdata[ECH_GND_MSB:0];
            end else if (r.dp_idx == ECH_IDX_HP2_GND) begin
                next_r.gnd_sel[1] = hwdata[ECH_GND_MSB:0];
            end else if (r.dp_idx == ECH_IDX_HP34_GND) begin
                next_r.gnd_sel[2] = hwdata[ECH_GND_MSB:0];
            end else if (r.dp_idx == ECH_IDX_LB_ONE) begin
                wr_lb[0] = 1'b1;
            end else if (r.dp_idx == ECH_IDX_LB_TWO) begin
                wr_lb[1] = 1'b1;
            end else if (r.dp_idx == ECH_IDX_IRQ_STAT) begin
                irq_clr = hwdata[3:0];
            end else if (r.dp_idx == ECH_IDX_IRQ_MASK) begin
                next_r.irq_mask = hwdata[3:0];
            end else if (r.dp_idx == ECH_IDX_MIN_CLK) begin
                next_r.min_clk = hwdata[CLK_W-1:0];
            end
        end

        // per path control, independent of each other
        for (int i = 0; i < 2; i++) begin
            if (wr_lb[i]) begin
                next_r.ena[i] = hwdata[ECH_ENA_BIT];
                next_r.src[i] = hwdata[ECH_SRC_MSB:ECH_SRC_LSB];
            end
            case (r.lb[i])
                ECH_LB_OFF: begin
                    if (wr_lb[i] && hwdata[ECH_ENA_BIT]) begin
                        next_r.lb[i] = ECH_LB_CHECK;
                    end
                end
                ECH_LB_CHECK: begin
                    if (!r.ena[i]) begin
                        next_r.lb[i] = ECH_LB_OFF;
                    end else if (system_clock_rate >= r.min_clk) begin
                        next_r.lb[i] = ECH_LB_ON;
                        irq_set[ECH_IRQ_ON_LSB + i] = 1'b1;
                    end else begin
                        next_r.lb[i] = ECH_LB_REFUSED;
                        irq_set[ECH_IRQ_REF_LSB + i] = 1'b1;
                    end
                end
                ECH_LB_ON: begin
                    if (!r.ena[i]) begin
                        next_r.lb[i] = ECH_LB_OFF;
                    end
                end
                ECH_LB_REFUSED: begin
                    if (!r.ena[i]) begin
                        next_r.lb[i] = ECH_LB_OFF;
                    end else if (wr_lb[i] && hwdata[ECH_ENA_BIT]) begin
                        next_r.lb[i] = ECH_LB_CHECK;
                    end
                end
                default: next_r.lb[i] = ECH_LB_OFF;
            endcase
            // samples go out only while the path is truly on
            if (sample_strobe && r.lb[i] == ECH_LB_ON && r.ena[i]) begin
                next_r.ref_valid[i] = 1'b1;
                next_r.ref_data[i] = pick_source(r.src[i], output_paths);
            end
        end

        // sticky events, set beats clear
        next_r.irq_status = (r.irq_status & ~irq_clr) | irq_set;
        next_r.irq = |(next_r.irq_status & next_r.irq_mask);

        next_r.gnd_route.headphone_one = route_ground(r.gnd_sel[0]);
        next_r.gnd_route.headphone_two = route_ground(r.gnd_sel[1]);
        next_r.gnd_route.headphone_three_four = route_ground(r.gnd_sel[2]);

        // address phase; read data taken from updated state
        if (hsel && hready && htrans[1]) begin
            next_r.dp_write = hwrite && (haddr[31:16] == 16'h0000);
            next_r.dp_idx = idx;
            if (!hwrite) begin
                next_r.hrdata = 32'h0000_0000;
                if (haddr[31:16] != 16'h0000) begin
                    next_r.hrdata = 32'h0000_0000;
                end else if (idx == ECH_IDX_HP1_GND) begin
                    next_r.hrdata[ECH_GND_MSB:0] = next_r.gnd_sel[0];
                end else if (idx == ECH_IDX_HP2_GND) begin
                    next_r.hrdata[ECH_GND_MSB:0] = next_r.gnd_sel[1];
                end else if (idx == ECH_IDX_HP34_GND) begin
                    next_r.hrdata[ECH_GND_MSB:0] = next_r.gnd_sel[2];
                end else if (idx == ECH_IDX_LB_ONE || idx == ECH_IDX_LB_TWO) begin
                    next_r.hrdata[ECH_ENA_BIT] = next_r.ena[idx[0]];
                    next_r.hrdata[ECH_STS_BIT] = (next_r.lb[idx[0]] == ECH_LB_ON);
                    next_r.hrdata[ECH_SRC_MSB:ECH_SRC_LSB] = next_r.src[idx[0]];
                end else if (idx == ECH_IDX_IRQ_STAT) begin
                    next_r.hrdata[3:0] = next_r.irq_status;
                end else if (idx == ECH_IDX_IRQ_MASK) begin
                    next_r.hrdata[3:0] = next_r.irq_mask;
                end else if (idx == ECH_IDX_MIN_CLK) begin
                    next_r.hrdata[CLK_W-1:0] = next_r.min_clk;
                end
            end
        end

        if (sys_rst) begin
            next_r = '0;
            next_r.gnd_sel[0] = ECH_HP1_GND_RST;
            next_r.gnd_sel[1] = ECH_HP2_GND_RST;
            next_r.gnd_sel[2] = ECH_HP34_GND_RST;
            next_r.irq_mask = ECH_IRQ_MASK_RST;
            next_r.min_clk = ECH_MIN_CLK_RST;
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    assign hrdata = r.hrdata;
    assign hreadyout = r.hreadyout;
    assign hresp = 1'b0;
    assign echo_ref_data = r.ref_data;
    assign echo_ref_valid = r.ref_valid;
    assign echo_ref_rate = r.rate;
    assign headphone_ground = r.gnd_route;
    assign irq = r.irq;

endmodule : ech_loopback_ctrl

//--- test/ech_lb_checker.sv
`timescale 1ns/100ps
module ech_lb_checker
    import ech_pkg::*;
#(parameter int SAMPLE_W = 24, parameter int RATE_W = 5) (
    input wire logic                     clk,
    input wire logic                     sys_rst,
    input wire logic                     sample_strobe,
    input wire logic [RATE_W-1:0]        output_rate,
    input wire logic [1:0][SAMPLE_W-1:0] echo_ref_data,
    input wire logic [1:0]               echo_ref_valid,
    input wire logic [RATE_W-1:0]        echo_ref_rate,
    input wire ech_hp_ground_type        headphone_ground
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_rate_follow: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> echo_ref_rate == $past(output_rate))
        else $error("echo rate off");
    chk_valid_cause: assert property (echo_ref_valid != 2'b00 |-> $past(sample_strobe))
        else $error("valid without strobe");
    chk_pulse_one: assert property (echo_ref_valid[0] |=> !echo_ref_valid[0])
        else $error("path one valid too long");
    chk_pulse_two: assert property (echo_ref_valid[1] |=> !echo_ref_valid[1])
        else $error("path two valid too long");
    chk_hold_one: assert property (!echo_ref_valid[0] |-> $stable(echo_ref_data[0]))
        else $error("path one data moved");
    chk_hold_two: assert property (!echo_ref_valid[1] |-> $stable(echo_ref_data[1]))
        else $error("path two data moved");
    chk_gnd_onehot: assert property ($onehot0(headphone_ground.headphone_one) &&
        $onehot0(headphone_ground.headphone_two) && $onehot0(headphone_ground.headphone_three_four))
        else $error("ground route not one-hot");
    chk_gnd_reset: assert property ($fell(sys_rst) |-> ##[0:3] headphone_ground == 18'h0_4101)
        else $error("ground route reset wrong");
    cover property (echo_ref_valid == 2'b11);
    cover property ($rose(echo_ref_valid[1]));
    cover property (headphone_ground.headphone_one.internal_analog_ground);
endmodule : ech_lb_checker
bind ech_loopback_ctrl ech_lb_checker #(.SAMPLE_W(SAMPLE_W), .RATE_W(RATE_W)) u_chk (.clk, .sys_rst,
    .sample_strobe, .output_rate, .echo_ref_data, .echo_ref_valid, .echo_ref_rate, .headphone_ground);

//--- test/ech_mixer_model.sv
`timescale 1ns/100ps
module ech_mixer_model
    import ech_pkg::*;
#(parameter int SAMPLE_W = 24) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    output logic      [7:0][SAMPLE_W-1:0] output_paths,
    output logic                          sample_strobe
);
    logic [3:0] phase;
    logic [7:0] frame;
    // strobe every ten cycles, samples renewed mid-period
    always_ff @(posedge clk) begin
        phase <= (sys_rst || phase == 4'h9) ? 4'h0 : phase + 4'h1;
        frame <= sys_rst ? 8'h00 : frame + 8'(phase == 4'h3);
    end
    assign sample_strobe = !sys_rst && phase == 4'h0;
    always_comb begin
        for (int i = 0; i < 8; i++) output_paths[i] = SAMPLE_W'({frame, 4'(i), 12'h05a3});
    end
endmodule : ech_mixer_model

//--- test/echo_loopback_and_hp_ground_select_tb_top.sv
`timescale 1ns/100ps
module echo_loopback_and_hp_ground_select_tb_top
    import ech_pkg::*;
;
    logic              clk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, hreadyout, hresp, sample_strobe, irq;
    logic [1:0]        htrans = 2'h0, echo_ref_valid;
    logic [31:0]       haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [7:0][23:0]  output_paths;
    logic [1:0][23:0]  echo_ref_data;
    logic [4:0]        echo_ref_rate;
    logic [3:0]        system_clock_rate = 4'h3;
    logic [4:0]        output_rate = 5'h0b;
    ech_hp_ground_type headphone_ground;
    int                error_cnt = 0, n_compared = 0, quiet = 0;
    ech_loopback_ctrl dut (.clk, .sys_rst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .output_paths, .sample_strobe, .output_rate,
        .system_clock_rate, .echo_ref_data, .echo_ref_valid, .echo_ref_rate, .headphone_ground, .irq);
    ech_mixer_model model (.clk, .sys_rst, .output_paths, .sample_strobe);
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one word transfer; a read compares against d
    task automatic bus(input logic w, input logic [13:0] i, input logic [7:0] d);
        htrans <= 2'h2;
        haddr <= {16'h0000, i, 2'b00};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        if (!w) chk(hrdata, {24'h00_0000, d});
        repeat (2) @(posedge clk);
    endtask : bus
    // second valid pulse of path p against source code c
    task automatic smp(input int p, input logic [3:0] c);
        logic [23:0] e;
        repeat (2) begin
            @(negedge clk);
            for (int k = 0; k < 40 && echo_ref_valid[p] !== 1'b1; k++) @(negedge clk);
        end
        e = c < 4'h6 ? output_paths[c] : c[3:1] == 3'h4 ? output_paths[c - 4'h2] : 24'h00_0000;
        chk({7'h00, echo_ref_valid[p], echo_ref_data[p]}, {8'h01, e});
    endtask : smp
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        bus(0, ECH_IDX_HP1_GND, 8'h00);
        bus(0, ECH_IDX_HP2_GND, 8'h02);
        bus(0, ECH_IDX_HP34_GND, 8'h02);
        bus(0, ECH_IDX_LB_ONE, 8'h00);
        bus(0, ECH_IDX_LB_TWO, 8'h00);
        chk(32'(headphone_ground), 32'h0000_4101);
        for (int c = 0; c < 8; c++) begin
            logic [5:0] g;
            g = 6'(c < 5 ? 1 << c : c == 5 ? 32 : 0);
            bus(1, ECH_IDX_HP1_GND, 8'(c));
            bus(1, ECH_IDX_HP34_GND, 8'(c));
            chk(32'(headphone_ground), 32'({g, 6'h04, g}));
        end
        bus(1, ECH_IDX_IRQ_MASK, 8'h0f);
        bus(1, ECH_IDX_LB_ONE, 8'h01);
        bus(0, ECH_IDX_LB_ONE, 8'h03);
        for (int c = 0; c < 10; c++) begin
            bus(1, ECH_IDX_LB_ONE, 8'(c * 4 + 1));
            smp(0, 4'(c));
        end
        system_clock_rate <= 4'h2;
        bus(1, ECH_IDX_LB_TWO, 8'h25);
        bus(0, ECH_IDX_LB_TWO, 8'h25);
        bus(0, ECH_IDX_IRQ_STAT, 8'h09);
        chk(32'(irq), 32'h0000_0001);
        bus(0, ECH_IDX_LB_ONE, 8'h27);
        smp(0, 4'h9);
        system_clock_rate <= 4'h3;
        bus(1, ECH_IDX_LB_TWO, 8'h21);
        bus(0, ECH_IDX_LB_TWO, 8'h23);
        smp(1, 4'h8);
        bus(1, ECH_IDX_IRQ_STAT, 8'h0f);
        bus(1, ECH_IDX_IRQ_MASK, 8'h00);
        chk(32'(irq), 32'h0000_0000);
        bus(1, ECH_IDX_LB_TWO, 8'h20);
        bus(0, ECH_IDX_LB_TWO, 8'h20);
        system_clock_rate <= 4'h2;
        bus(1, ECH_IDX_LB_TWO, 8'h21);
        bus(0, ECH_IDX_IRQ_STAT, 8'h08);
        chk(32'(irq), 32'h0000_0000);
        bus(1, ECH_IDX_IRQ_MASK, 8'h08);
        chk(32'(irq), 32'h0000_0001);
        bus(1, ECH_IDX_LB_ONE, 8'h26);
        bus(0, ECH_IDX_LB_ONE, 8'h24);
        repeat (30) @(posedge clk) quiet += int'(echo_ref_valid[0]);
        chk(32'(quiet), 32'h0000_0000);
        bus(0, 14'h0452, 8'h00);
        chk(32'(echo_ref_rate), 32'h0000_000b);
        output_rate <= 5'h15;
        repeat (2) @(posedge clk);
        chk(32'(echo_ref_rate), 32'h0000_0015);
        chk(32'(hresp), 32'h0000_0000);
        final_report;
    end
endmodule : echo_loopback_and_hp_ground_select_tb_top
